// *** src/rpic_pkg.sv ***
/*
  Constants for the reset, power-mode and interrupt controller.
  Assumes one system clock that samples the oscillator input as an ordinary signal.
*/
package rpic_pkg;
  // ==========================================================
  // Oscillator and machine-cycle timing.
  localparam int OSC_PER_MCYCLE = 12;
  localparam int RESET_OSC_PERIODS = 24;
  localparam logic [4:0] RESET_MCYCLES = 5'(RESET_OSC_PERIODS / OSC_PER_MCYCLE);
  localparam logic [3:0] PHASE_LAST = 4'(OSC_PER_MCYCLE / 2 - 1);
  // ==========================================================
  // Reset values and vectors.
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_EXT_A = 11'h003;
  localparam logic [10:0] VEC_CTR = 11'h00B;
  localparam logic [10:0] VEC_EXT_B = 11'h013;
  localparam logic [10:0] VEC_FIXED = 11'h01B;
  // ==========================================================
  // Operating modes.
  typedef enum logic [3:0] {
    RPIC_RESET = 4'b0001,
    RPIC_RUN = 4'b0010,
    RPIC_IDLE = 4'b0100,
    RPIC_DOWN = 4'b1000
  } rpic_mode_t;
endpackage : rpic_pkg

// *** src/rpic_ctrl.sv ***
/*
  Reset, clock-divide, idle and power-down sequencing with interrupt vectoring.
  Assumes the core pulses its mode requests at instruction end and holds stack pushes itself.
*/
// Notes on behaviour
// - Reset when reset input stays high for 24 oscillator periods while running.
// - Internal clock comes from oscillator input through a divide-by-two stage.
// - Idle halts the CPU after the requesting instruction; peripherals keep running.
// - Idle keeps CPU state, data RAM and special registers unchanged.
// - Any enabled interrupt ends idle and enters its service routine.
// - Hardware reset during idle ends idle like a power-on reset.
// - Power-down stops the oscillator after the requesting instruction.
// - Power-down keeps only data RAM contents.
// - Only hardware reset leaves power-down; interrupts do not wake it.
// - Port pins keep driving latched data in idle and power-down.
// - Reset loads stack pointer with 07; push increments before writing.
// - Vectors: reset 000, ext a 003, counter 00B, ext b 013, fixed timer 01B.
// - Simultaneous requests resolved in fixed order ext a, counter, ext b, fixed.
`timescale 1ns/100ps
`default_nettype none
module rpic_ctrl
  import rpic_pkg::*;
(
  // System clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Pins from the outside.
  input wire logic osc_input,
  input wire logic reset_pin,
  // Requests from the core.
  input wire logic idle_req,
  input wire logic down_req,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic sp_load,
  input wire logic [7:0] sp_wdata,
  // Enabled interrupt requests.
  input wire logic ext_irq_a,
  input wire logic ctr_irq,
  input wire logic ext_irq_b,
  input wire logic fixed_irq,
  input wire logic irq_ack,
  // Outputs to the core and peripherals.
  output logic int_clk_en,
  output logic mcycle_en,
  output logic cpu_run,
  output logic periph_run,
  output logic osc_enable,
  output logic core_reset,
  output logic port_hold,
  output logic vec_valid,
  output logic [10:0] vec_addr,
  output logic [7:0] stack_pointer
);
  // ==========================================================
  // State record.
  typedef struct packed {
    logic osc_prev;
    logic half;
    logic [3:0] phase;
    logic [4:0] rst_count;
    rpic_mode_t mode;
    logic wake_pend;
    logic vec_valid;
    logic [10:0] vec_addr;
    logic [7:0] sp;
  } rpic_state_t;

  // Field values loaded by the synchronous reset.
  localparam rpic_state_t ST_AFTER_RESET = '{
    osc_prev: 1'b0,
    half: 1'b0,
    phase: 4'h0,
    rst_count: 5'h00,
    mode: RPIC_RESET,
    wake_pend: 1'b0,
    vec_valid: 1'b0,
    vec_addr: VEC_RESET,
    sp: SP_RESET
  };

  rpic_state_t st;
  rpic_state_t next_st;
  logic osc_rise;
  logic mc_tick;
  logic any_irq;

  // Picks the vector of the highest-priority pending request.
  function automatic logic [10:0] rpic_pick(input logic a, input logic c, input logic b);
    if (a) begin
      rpic_pick = VEC_EXT_A;
    end else if (c) begin
      rpic_pick = VEC_CTR;
    end else if (b) begin
      rpic_pick = VEC_EXT_B;
    end else begin
      rpic_pick = VEC_FIXED;
    end
  endfunction : rpic_pick

  // ==========================================================
  // Next-state logic.
  always_comb begin
    next_st = st;
    // The oscillator input is plain data; a rise is found against last cycle's sample.
    osc_rise = osc_input && !st.osc_prev && (st.mode != RPIC_DOWN);
    next_st.osc_prev = osc_input;
    mc_tick = 1'b0;
    any_irq = ext_irq_a | ctr_irq | ext_irq_b | fixed_irq;
    if (osc_rise) begin
      next_st.half = ~st.half;
      if (st.half) begin
        if (st.phase == PHASE_LAST) begin
          next_st.phase = 4'h0;
          mc_tick = 1'b1;
        end else begin
          next_st.phase = st.phase + 4'h1;
        end
      end
    end
    // A low sample clears the count, so only consecutive high samples reach the limit.
    if (mc_tick) begin
      if (reset_pin) begin
        if (st.rst_count != RESET_MCYCLES) begin
          next_st.rst_count = st.rst_count + 5'h01;
        end
      end else begin
        next_st.rst_count = 5'h00;
      end
    end
    if (st.vec_valid && irq_ack) begin
      next_st.vec_valid = 1'b0;
    end
    case (st.mode)
      RPIC_RESET: begin
        next_st.sp = SP_RESET;
        if (mc_tick && !reset_pin) begin
          next_st.mode = RPIC_RUN;
          next_st.vec_addr = VEC_RESET;
        end
      end
      RPIC_RUN: begin
        // Power-down wins when the core asks for both modes in one cycle.
        if (down_req) begin
          next_st.mode = RPIC_DOWN;
        end else if (idle_req) begin
          next_st.mode = RPIC_IDLE;
        end else if (any_irq && !st.vec_valid) begin
          next_st.vec_valid = 1'b1;
          next_st.vec_addr = rpic_pick(ext_irq_a, ctr_irq, ext_irq_b);
        end
        if (sp_load) begin
          next_st.sp = sp_wdata;
        end else if (sp_push) begin
          next_st.sp = st.sp + 8'h01;
        end else if (sp_pop) begin
          next_st.sp = st.sp - 8'h01;
        end
      end
      RPIC_IDLE: begin
        if (any_irq) begin
          next_st.wake_pend = 1'b1;
        end
        if (st.wake_pend && mc_tick) begin
          next_st.wake_pend = 1'b0;
          next_st.mode = RPIC_RUN;
          // A vector the core has not taken yet is kept rather than overwritten.
          if (!st.vec_valid) begin
            next_st.vec_valid = 1'b1;
            next_st.vec_addr = rpic_pick(ext_irq_a, ctr_irq, ext_irq_b);
          end
        end
      end
      RPIC_DOWN: begin
        next_st.wake_pend = 1'b0;
      end
      default: begin
        next_st.mode = RPIC_RESET;
      end
    endcase
    // The reset checks come last so that they win over every mode change above.
    if (st.rst_count == RESET_MCYCLES && reset_pin) begin
      next_st.mode = RPIC_RESET;
      next_st.wake_pend = 1'b0;
      next_st.vec_valid = 1'b0;
    end
    // No machine cycles run while the oscillator is stopped, so the pin level is taken directly.
    if (st.mode == RPIC_DOWN && reset_pin) begin
      next_st.mode = RPIC_RESET;
      next_st.rst_count = 5'h00;
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= ST_AFTER_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs.
  // Mode levels are decoded from the state; vector and pointer come straight from flip-flops.
  assign int_clk_en = osc_rise && st.half;
  assign mcycle_en = mc_tick;
  assign cpu_run = (st.mode == RPIC_RUN);
  assign periph_run = (st.mode == RPIC_RUN) || (st.mode == RPIC_IDLE);
  assign osc_enable = (st.mode != RPIC_DOWN);
  assign core_reset = (st.mode == RPIC_RESET);
  assign port_hold = (st.mode == RPIC_IDLE) || (st.mode == RPIC_DOWN);
  assign vec_valid = st.vec_valid;
  assign vec_addr = st.vec_addr;
  assign stack_pointer = st.sp;
endmodule : rpic_ctrl
`default_nettype wire

// *** bench/rpic_ctrl_checker.sv ***
/* Assertions on the rpic_ctrl ports. Assumes the bind below. */
`timescale 1ns/100ps
`default_nettype none
module rpic_ctrl_checker import rpic_pkg::*; (input wire logic clock, rst, osc_input,
  reset_pin, idle_req, down_req, irq_ack, int_clk_en, mcycle_en, cpu_run, periph_run,
  osc_enable, core_reset, port_hold, vec_valid, input wire logic [10:0] vec_addr,
  input wire logic [7:0] stack_pointer);
  // ========
  // Mode, vector and pointer relations.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_reset_load: assert property ($fell(rst) |-> core_reset && stack_pointer == SP_RESET)
    else $error("pointer not reset");
  chk_idle_halt: assert property (idle_req && !down_req && cpu_run && !reset_pin |=>
    !cpu_run && periph_run && port_hold) else $error("idle entry");
  chk_down_stop: assert property (down_req && cpu_run && !reset_pin |=>
    !osc_enable && !cpu_run && port_hold) else $error("down entry");
  chk_down_stay: assert property (!osc_enable && !reset_pin |=> !osc_enable && !cpu_run)
    else $error("left down");
  chk_vec_hold: assert property (vec_valid && !irq_ack && !reset_pin |=>
    vec_valid && $stable(vec_addr)) else $error("vector lost");
  chk_wake_tick: assert property ($rose(vec_valid) && !$past(cpu_run) |-> $past(mcycle_en))
    else $error("wake off tick");
  chk_int_clock: assert property (int_clk_en |-> $rose(osc_input))
    else $error("internal clock");
  chk_idle_keep: assert property (port_hold && !reset_pin |=> $stable(stack_pointer))
    else $error("pointer moved");
  cover property (port_hold ##1 vec_valid);
  cover property (!osc_enable ##1 core_reset);
  cover property (mcycle_en && core_reset);
endmodule : rpic_ctrl_checker
bind rpic_ctrl rpic_ctrl_checker chk_inst (.*);
`default_nettype wire

// *** bench/rpic_pins_model.sv ***
/* Oscillator source and reset driver. Assumes one system clock. */
`timescale 1ns/100ps
`default_nettype none
module rpic_pins_model (input wire logic clock, osc_enable, want_reset,
  output logic osc_input, reset_pin);
  // ========
  // The source toggles each clock and stands still once the device stops it.
  // An unknown enable right after start counts as running, so the source never turns unknown.
  initial begin
    osc_input = 1'b0;
    forever begin
      @(posedge clock);
      osc_input <= #10 (osc_enable === 1'b0) ? osc_input : !osc_input;
    end
  end
  initial begin
    reset_pin = 1'b1;
    forever begin
      @(posedge clock);
      reset_pin <= #10 want_reset;
    end
  end
endmodule : rpic_pins_model
`default_nettype wire

// *** bench/rpic_ctrl_bench.sv ***
/* Bench for rpic_ctrl. Assumes the pin model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module rpic_ctrl_bench import rpic_pkg::*;;
  // ========
  // Stimulus, instances and scenarios.
  logic clock = 0, rst = 1, want_reset = 1, idle_req = 0, down_req = 0, sp_push = 0, irq_ack = 0;
  logic [3:0] irq = 0;
  logic osc_input, reset_pin, int_clk_en, mcycle_en, cpu_run, periph_run, osc_enable;
  logic core_reset, port_hold, vec_valid;
  logic [10:0] vec_addr;
  logic [7:0] stack_pointer;
  int n_mismatch = 0, n_compared = 0;
  always #50 clock = !clock;
  rpic_pins_model rpic_pins_model_inst (.clock, .osc_enable, .want_reset, .osc_input, .reset_pin);
  rpic_ctrl rpic_ctrl_inst (.clock, .rst, .osc_input, .reset_pin, .idle_req, .down_req, .sp_push,
    .sp_pop(1'b0), .sp_load(1'b0), .sp_wdata(8'h00), .ext_irq_a(irq[3]), .ctr_irq(irq[2]),
    .ext_irq_b(irq[1]), .fixed_irq(irq[0]), .irq_ack, .int_clk_en, .mcycle_en, .cpu_run,
    .periph_run, .osc_enable, .core_reset, .port_hold, .vec_valid, .vec_addr, .stack_pointer);
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask : tick
  task automatic chk(input string what, input logic [10:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask : pulse
  task automatic wait_run();
    int i = 0;
    while (cpu_run !== 1'b1) begin
      if (++i > 400) begin
        n_mismatch++;
        stop_test();
      end
      tick(1);
    end
  endtask : wait_run
  task automatic t_clock();
    int n_ic = 0;
    int n_mc = 0;
    repeat (48) begin
      @(negedge clock);
      n_ic += int_clk_en;
      n_mc += mcycle_en;
    end
    tick(1);
    chk("int_clk_en pulses", 11'h00C, n_ic[10:0]);
    chk("mcycle_en pulses", 11'h002, n_mc[10:0]);
  endtask : t_clock
  task automatic t_prio();
    logic [10:0] vec[4] = '{VEC_EXT_A, VEC_CTR, VEC_EXT_B, VEC_FIXED};
    for (int k = 0; k < 4; k++) begin
      irq = 4'hF >> k;
      tick(1);
      chk("vec_addr", vec[k], vec_addr);
      chk("vec_valid", 11'h001, vec_valid);
      irq = 0;
      pulse(irq_ack);
      chk("vec_valid", 11'h000, vec_valid);
    end
  endtask : t_prio
  task automatic t_idle();
    pulse(idle_req);
    chk("cpu_run", 0, cpu_run);
    chk("periph_run", 1, periph_run);
    chk("port_hold", 1, port_hold);
    pulse(sp_push);
    tick(30);
    chk("stack_pointer", 11'h008, stack_pointer);
    irq = 4'h4;
    wait_run();
    chk("vec_addr", VEC_CTR, vec_addr);
    irq = 0;
    pulse(irq_ack);
  endtask : t_idle
  task automatic t_down();
    pulse(down_req);
    chk("osc_enable", 0, osc_enable);
    irq = 4'h8;
    tick(80);
    chk("cpu_run", 0, cpu_run);
    irq = 0;
    want_reset = 1;
    tick(2);
    chk("core_reset", 1, core_reset);
    tick(50);
    want_reset = 0;
    wait_run();
    chk("stack_pointer", SP_RESET, stack_pointer);
  endtask : t_down
  task automatic t_idle_reset();
    pulse(sp_push);
    pulse(idle_req);
    want_reset = 1;
    tick(80);
    chk("core_reset", 1, core_reset);
    want_reset = 0;
    wait_run();
    chk("stack_pointer", SP_RESET, stack_pointer);
  endtask : t_idle_reset
  initial begin
    tick(4);
    rst = 0;
    tick(60);
    want_reset = 0;
    wait_run();
    chk("stack_pointer", SP_RESET, stack_pointer);
    chk("vec_addr", VEC_RESET, vec_addr);
    pulse(sp_push);
    chk("stack_pointer", 11'h008, stack_pointer);
    t_clock();
    t_prio();
    t_idle();
    t_down();
    t_idle_reset();
    stop_test();
  end
endmodule : rpic_ctrl_bench
`default_nettype wire
